// file: rtl/ebi_bus_ctrl.sv
// External basic bus controller for normal mode: area 0 select, lane alignment,
// strobes and two- or three-state cycles. Assumes requests come from same-clock logic.
// Notes on behaviour
// - Normal mode: one 64-kbyte space, part of area 0, no partitioning.
// - ROM disabled: all but RAM and I/O registers is external.
// - ROM enabled: all but ROM, RAM and I/O registers is external.
// - RAM mapped only when RAM enable is 1; otherwise external.
// - Basic interface used; only the area 0 select is ever driven low.
// - Area select goes low while its external space is accessed; areas 0-3.
// - Select pins output only when direction set; ROM off: area 0 output.
// - ROM on: all selects inputs after reset until direction is written; area 0 is output for the first two clocks after reset.
// - One state is one clock period; cycles are one to three states.
// - On-chip ROM and RAM accesses finish in one state.
// - Internal I/O register accesses take two states.
// - External cycles two or three states; waits only in three-state.
// - Lanes chosen from area width and transfer size.
// - 8-bit area: upper lane only; word two bytes, long four.
// - 16-bit area: byte or word per cycle; long as two words.
// - 16-bit byte: even address upper lane, odd address lower lane.
// - Read strobe asserted on every read whichever lane.
// - Upper write strobe for upper lane, lower for lower; word both.
// - Unused lane on read is ignored input; on write not driven.
// - 8-bit area keeps lower write strobe high; 2-state has no waits.
// - Width bit 0 means 16-bit area, 1 means 8-bit area.
// - State bit 0 gives two states, 1 gives three states.
// - Two-bit wait field adds 0-3 waits between second and third state.
// - Reset: three-state, three waits, external wait input disabled.
`timescale 1ns/100ps
`include "ebi_defs.svh"
module ebi_bus_ctrl (
   input wire logic clock_in,
   input wire logic reset_n_in,
   input wire logic req_valid_in,
   input wire logic [15:0] req_addr_in,
   input wire logic req_write_in,
   input wire logic [1:0] req_size_in,
   input wire logic [31:0] req_wdata_in,
   output logic req_ready_out,
   output logic resp_done_out,
   output logic [31:0] resp_rdata_out,
   output logic int_access_out,
   output logic [1:0] int_target_out,
   input wire logic rom_enable_in,
   input wire logic onchip_ram_enable_in,
   input wire logic cs_dir_write_in,
   input wire logic [3:0] cs_dir_in,
   input wire logic cfg_write_in,
   input wire logic [3:0] area_width_bit_in,
   input wire logic [3:0] area_state_bit_in,
   input wire logic [3:0] area_wait_hi_bit_in,
   input wire logic [3:0] area_wait_lo_bit_in,
   output logic wait_input_enable_out,
   output logic [15:0] ext_addr_out,
   output logic [15:0] ext_data_out,
   output logic ext_data_hi_oe_out,
   output logic ext_data_lo_oe_out,
   input wire logic [15:0] ext_data_in,
   output logic read_strobe_n_out,
   output logic upper_write_strobe_n_out,
   output logic lower_write_strobe_n_out,
   output logic [3:0] area_select_n_out,
   output logic [3:0] area_select_oe_out
);
   ebi_link_if lk ();
   ebi_addr_decode u_dec (.clock_in(clock_in), .reset_n_in(reset_n_in), .lk(lk));
   ebi_state_timer u_tmr (.clock_in(clock_in), .reset_n_in(reset_n_in), .lk(lk));

   ebi_pkg::ebi_fsm_e state_reg;
   logic [3:0] width_reg, ast_reg, whi_reg, wlo_reg, dir_reg, cs_oe_reg, cs_n_reg;
   logic dir_set_reg, rom_s1_reg, rom_s2_reg, ready_reg, done_reg, int_access_reg;
   logic [15:0] din_s1_reg, din_s2_reg, addr_reg, dout_reg;
   logic [31:0] rdata_reg, wsh_reg;
   logic [1:0] int_target_reg, lanes_reg, tag1_l_reg, tag2_l_reg;
   logic oe_hi_reg, oe_lo_reg, rd_n_reg, hwr_n_reg, lwr_n_reg, wide_reg, write_reg;
   logic tag1_v_reg, tag1_f_reg, tag2_v_reg, tag2_f_reg;
   logic [2:0] left_reg;
   ebi_pkg::ebi_size_e size_reg;

   function automatic logic [1:0] ebi_lanes(input logic wide, input ebi_pkg::ebi_size_e sz, input logic a0);
      if (!wide) return `EBI_LANE_HI;
      // Size code 3 falls through as a byte
      if (sz == ebi_pkg::EBI_SZ_WORD || sz == ebi_pkg::EBI_SZ_LONG) return `EBI_LANE_BOTH;
      return a0 ? `EBI_LANE_LO : `EBI_LANE_HI;
   endfunction

   function automatic logic [2:0] ebi_beats(input logic wide, input ebi_pkg::ebi_size_e sz);
      case (sz)
         ebi_pkg::EBI_SZ_WORD: return wide ? `EBI_N1 : `EBI_N2;
         ebi_pkg::EBI_SZ_LONG: return wide ? `EBI_N2 : `EBI_N4;
         default: return `EBI_N1;
      endcase
   endfunction

   function automatic logic [31:0] ebi_align(input logic [31:0] d, input ebi_pkg::ebi_size_e sz);
      case (sz)
         ebi_pkg::EBI_SZ_WORD: return {d[15:0], 16'h0000};
         ebi_pkg::EBI_SZ_LONG: return d;
         default: return {d[7:0], 24'h000000};
      endcase
   endfunction

   // Beat setup, shared by the first beat and each following one
   ebi_pkg::ebi_size_e req_size, go_size;
   logic accept, first_go, next_go, go, last_beat, act, go_wide, go_write, done_next;
   logic [15:0] go_addr, go_data;
   logic [31:0] go_wsh;
   logic [1:0] go_lanes;
   logic [2:0] ext_len;
   assign req_size = ebi_pkg::ebi_size_e'(req_size_in);
   assign accept = (state_reg == ebi_pkg::EBI_IDLE) && req_valid_in && ready_reg;
   assign first_go = accept && (lk.target == ebi_pkg::EBI_TGT_EXT);
   assign last_beat = (left_reg == `EBI_N1);
   assign next_go = (state_reg == ebi_pkg::EBI_EXT) && lk.last && !last_beat;
   assign go = first_go || next_go;
   assign act = (state_reg == ebi_pkg::EBI_EXT) && !lk.last && (lk.idx == 3'h0);
   assign go_wide = first_go ? !width_reg[`EBI_AREA0] : wide_reg;
   assign go_size = first_go ? req_size : size_reg;
   assign go_write = first_go ? req_write_in : write_reg;
   assign go_addr = first_go ? req_addr_in : addr_reg + (wide_reg ? 16'h0002 : 16'h0001);
   assign go_wsh = first_go ? ebi_align(req_wdata_in, req_size) :
                   (wide_reg ? {wsh_reg[15:0], 16'h0000} : {wsh_reg[23:0], 8'h00});
   assign go_lanes = ebi_lanes(go_wide, go_size, go_addr[0]);
   assign go_data = (go_lanes == `EBI_LANE_BOTH) ? go_wsh[31:16] :
                    (go_lanes == `EBI_LANE_HI) ? {go_wsh[31:24], 8'h00} : {8'h00, go_wsh[31:24]};
   // Waits only exist in three-state areas, placed before the final state
   assign ext_len = ast_reg[`EBI_AREA0] ?
                    `EBI_ST_THREE + {1'b0, whi_reg[`EBI_AREA0], wlo_reg[`EBI_AREA0]} : `EBI_ST_TWO;
   assign lk.addr = req_addr_in;
   assign lk.rom_en = rom_s2_reg;
   assign lk.ram_en = onchip_ram_enable_in;
   assign lk.start = go || (accept && !first_go);
   assign lk.len = go ? ext_len :
                   ((lk.target == ebi_pkg::EBI_TGT_IO) ? `EBI_ST_IO : `EBI_ST_MEM);
   assign done_next = ((state_reg == ebi_pkg::EBI_INT) && lk.last) ||
                      ((state_reg == ebi_pkg::EBI_EXT) && lk.last && last_beat && write_reg) ||
                      ((state_reg == ebi_pkg::EBI_DRAIN) && tag2_v_reg && tag2_f_reg);

   // Pin synchronisers
   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rom_s1_reg <= 1'b0;
         rom_s2_reg <= 1'b0;
         din_s1_reg <= 16'h0000;
         din_s2_reg <= 16'h0000;
      end else begin
         rom_s1_reg <= rom_enable_in;
         rom_s2_reg <= rom_s1_reg;
         din_s1_reg <= ext_data_in;
         din_s2_reg <= din_s1_reg;
      end
   end

   // Area configuration and select directions
   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         width_reg <= `EBI_RST_WIDTH;
         ast_reg <= `EBI_RST_STATE;
         whi_reg <= `EBI_RST_WAIT;
         wlo_reg <= `EBI_RST_WAIT;
         dir_reg <= `EBI_DIR_ROM_ON;
         dir_set_reg <= 1'b0;
         cs_oe_reg <= `EBI_DIR_ROM_ON;
      end else begin
         if (cfg_write_in) begin
            width_reg <= area_width_bit_in;
            ast_reg <= area_state_bit_in;
            whi_reg <= area_wait_hi_bit_in;
            wlo_reg <= area_wait_lo_bit_in;
         end
         if (cs_dir_write_in) begin
            dir_reg <= cs_dir_in;
            dir_set_reg <= 1'b1;
         end
         // Strap decides directions until software writes them
         cs_oe_reg <= dir_set_reg ? dir_reg : (rom_s2_reg ? `EBI_DIR_ROM_ON : `EBI_DIR_ROM_OFF);
      end
   end

   // Sequencer
   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         state_reg <= ebi_pkg::EBI_IDLE;
      end else begin
         unique case (state_reg)
            ebi_pkg::EBI_IDLE: if (accept) state_reg <= first_go ? ebi_pkg::EBI_EXT : ebi_pkg::EBI_INT;
            ebi_pkg::EBI_INT: if (lk.last) state_reg <= ebi_pkg::EBI_IDLE;
            ebi_pkg::EBI_EXT: begin
               if (lk.last && last_beat) state_reg <= write_reg ? ebi_pkg::EBI_IDLE : ebi_pkg::EBI_DRAIN;
            end
            ebi_pkg::EBI_DRAIN: if (tag2_v_reg && tag2_f_reg) state_reg <= ebi_pkg::EBI_IDLE;
         endcase
      end
   end

   // Handshake and internal access
   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         ready_reg <= 1'b1;
         done_reg <= 1'b0;
         int_access_reg <= 1'b0;
         int_target_reg <= 2'h0;
      end else begin
         done_reg <= done_next;
         if (accept) begin
            ready_reg <= 1'b0;
            int_target_reg <= lk.target;
         end else if (done_next) begin
            ready_reg <= 1'b1;
         end
         if (accept && !first_go) begin
            int_access_reg <= 1'b1;
         end else if ((state_reg == ebi_pkg::EBI_INT) && lk.last) begin
            int_access_reg <= 1'b0;
         end
      end
   end

   // Beat bookkeeping; width fixes splitting into bytes or words
   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         wide_reg <= 1'b0;
         write_reg <= 1'b0;
         size_reg <= ebi_pkg::EBI_SZ_BYTE;
         lanes_reg <= `EBI_LANE_HI;
         left_reg <= `EBI_N1;
         wsh_reg <= 32'h00000000;
      end else if (go) begin
         wide_reg <= go_wide;
         write_reg <= go_write;
         size_reg <= go_size;
         lanes_reg <= go_lanes;
         left_reg <= first_go ? ebi_beats(go_wide, go_size) : left_reg - 3'h1;
         wsh_reg <= go_wsh;
      end
   end

   // Pins: select and address held for the beat, strobes from second state
   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         cs_n_reg <= `EBI_CS_NONE;
         addr_reg <= 16'h0000;
         dout_reg <= 16'h0000;
         oe_hi_reg <= 1'b0;
         oe_lo_reg <= 1'b0;
         rd_n_reg <= 1'b1;
         hwr_n_reg <= 1'b1;
         lwr_n_reg <= 1'b1;
      end else if (go) begin
         cs_n_reg <= `EBI_CS_AREA0;
         addr_reg <= go_addr;
         dout_reg <= go_data;
         oe_hi_reg <= go_write && go_lanes[1];
         oe_lo_reg <= go_write && go_lanes[0];
         rd_n_reg <= 1'b1;
         hwr_n_reg <= 1'b1;
         lwr_n_reg <= 1'b1;
      end else if (act) begin
         rd_n_reg <= write_reg;
         hwr_n_reg <= !(write_reg && lanes_reg[1]);
         lwr_n_reg <= !(write_reg && lanes_reg[0]);
      end else if ((state_reg == ebi_pkg::EBI_EXT) && lk.last) begin
         cs_n_reg <= `EBI_CS_NONE;
         oe_hi_reg <= 1'b0;
         oe_lo_reg <= 1'b0;
         rd_n_reg <= 1'b1;
         hwr_n_reg <= 1'b1;
         lwr_n_reg <= 1'b1;
      end
   end

   // Read capture follows the synchroniser by two edges
   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         tag1_v_reg <= 1'b0;
         tag1_f_reg <= 1'b0;
         tag1_l_reg <= `EBI_LANE_HI;
         tag2_v_reg <= 1'b0;
         tag2_f_reg <= 1'b0;
         tag2_l_reg <= `EBI_LANE_HI;
         rdata_reg <= 32'h00000000;
      end else begin
         tag1_v_reg <= (state_reg == ebi_pkg::EBI_EXT) && lk.last && !write_reg;
         tag1_f_reg <= last_beat;
         tag1_l_reg <= lanes_reg;
         tag2_v_reg <= tag1_v_reg;
         tag2_f_reg <= tag1_f_reg;
         tag2_l_reg <= tag1_l_reg;
         if (accept) begin
            rdata_reg <= 32'h00000000;
         end else if (tag2_v_reg) begin
            // Unused lane is never looked at
            if (tag2_l_reg == `EBI_LANE_BOTH) begin
               rdata_reg <= {rdata_reg[15:0], din_s2_reg};
            end else if (tag2_l_reg == `EBI_LANE_HI) begin
               rdata_reg <= {rdata_reg[23:0], din_s2_reg[15:8]};
            end else begin
               rdata_reg <= {rdata_reg[23:0], din_s2_reg[7:0]};
            end
         end
      end
   end

   assign req_ready_out = ready_reg;
   assign resp_done_out = done_reg;
   assign resp_rdata_out = rdata_reg;
   assign int_access_out = int_access_reg;
   assign int_target_out = int_target_reg;
   assign wait_input_enable_out = 1'b0;
   assign ext_addr_out = addr_reg;
   assign ext_data_out = dout_reg;
   assign ext_data_hi_oe_out = oe_hi_reg;
   assign ext_data_lo_oe_out = oe_lo_reg;
   assign read_strobe_n_out = rd_n_reg;
   assign upper_write_strobe_n_out = hwr_n_reg;
   assign lower_write_strobe_n_out = lwr_n_reg;
   assign area_select_n_out = cs_n_reg;
   assign area_select_oe_out = cs_oe_reg;

   a_lwr_narrow: assert property (
      @(posedge clock_in) disable iff (!reset_n_in)
      (state_reg == ebi_pkg::EBI_EXT && !wide_reg) |-> lwr_n_reg)
      else $error("lower write strobe active in 8-bit area");
   a_cs_steady: assert property (
      @(posedge clock_in) disable iff (!reset_n_in)
      (state_reg == ebi_pkg::EBI_EXT && !lk.last) |=> ($stable(addr_reg) && $stable(cs_n_reg)))
      else $error("address or select moved inside a cycle");
   a_strobe_release: assert property (
      @(posedge clock_in) disable iff (!reset_n_in)
      (state_reg == ebi_pkg::EBI_EXT && lk.last) |=> (rd_n_reg && hwr_n_reg && lwr_n_reg))
      else $error("strobe not released after last state");
   a_read_strobe: assert property (
      @(posedge clock_in) disable iff (!reset_n_in)
      (state_reg == ebi_pkg::EBI_EXT && lk.idx == 3'h1 && !write_reg) |-> (!rd_n_reg && !cs_n_reg[0]))
      else $error("read strobe or select missing");
   a_word_both: assert property (
      @(posedge clock_in) disable iff (!reset_n_in)
      (state_reg == ebi_pkg::EBI_EXT && lk.idx == 3'h1 && write_reg && lanes_reg == `EBI_LANE_BOTH)
      |-> (!hwr_n_reg && !lwr_n_reg && rd_n_reg))
      else $error("word write lacks both strobes");
   a_byte_lane: assert property (
      @(posedge clock_in) disable iff (!reset_n_in)
      (state_reg == ebi_pkg::EBI_EXT && lk.idx == 3'h1 && write_reg && wide_reg &&
       size_reg == ebi_pkg::EBI_SZ_BYTE) |-> (addr_reg[0] ? (hwr_n_reg && !lwr_n_reg) : (!hwr_n_reg && lwr_n_reg)))
      else $error("byte lane does not follow address parity");
   a_read_hiz: assert property (
      @(posedge clock_in) disable iff (!reset_n_in)
      (state_reg == ebi_pkg::EBI_EXT && !write_reg) |-> (!oe_hi_reg && !oe_lo_reg))
      else $error("data bus driven during read");
   a_int_one: assert property (
      @(posedge clock_in) disable iff (!reset_n_in)
      (accept && (lk.target == ebi_pkg::EBI_TGT_ROM || lk.target == ebi_pkg::EBI_TGT_RAM)) |-> ##2 done_reg)
      else $error("on-chip memory access not one state");
   a_int_io_two: assert property (
      @(posedge clock_in) disable iff (!reset_n_in)
      (accept && lk.target == ebi_pkg::EBI_TGT_IO) |-> ##2 !done_reg ##1 done_reg)
      else $error("I/O register access not two states");
   a_cs_only0: assert property (
      @(posedge clock_in) disable iff (!reset_n_in)
      1'b1 |-> (cs_n_reg[3:1] == 3'h7))
      else $error("select other than area 0 driven low");
endmodule // ebi_bus_ctrl

// file: rtl/ebi_defs.svh
// Constants for the external basic bus interface: map, timing, resets.
// Assumes normal mode with a 16-bit address space and area 0 only.
`ifndef EBI_DEFS_SVH
`define EBI_DEFS_SVH
`define EBI_ROM_LO 16'h0000
`define EBI_ROM_HI 16'h7fff
`define EBI_RAM_LO 16'hf780
`define EBI_RAM_HI 16'hff7f
`define EBI_IO_LO 16'hff80
`define EBI_IO_HI 16'hffff
`define EBI_ST_MEM 3'h1
`define EBI_ST_IO 3'h2
`define EBI_ST_TWO 3'h2
`define EBI_ST_THREE 3'h3
`define EBI_AREA0 0
`define EBI_RST_WIDTH 4'hf
`define EBI_RST_STATE 4'hf
`define EBI_RST_WAIT 4'hf
`define EBI_DIR_ROM_OFF 4'h1
`define EBI_DIR_ROM_ON 4'h0
`define EBI_CS_AREA0 4'he
`define EBI_CS_NONE 4'hf
`define EBI_LANE_HI 2'h2
`define EBI_LANE_LO 2'h1
`define EBI_LANE_BOTH 2'h3
`define EBI_N1 3'h1
`define EBI_N2 3'h2
`define EBI_N4 3'h4
`endif

// file: rtl/ebi_pkg.sv
// Types shared by the external bus interface modules.
// Assumes nothing beyond a SystemVerilog compiler.
package ebi_pkg;
   typedef enum logic [1:0] {EBI_SZ_BYTE, EBI_SZ_WORD, EBI_SZ_LONG} ebi_size_e;
   typedef enum logic [1:0] {EBI_TGT_EXT, EBI_TGT_ROM, EBI_TGT_RAM, EBI_TGT_IO} ebi_target_e;
   typedef enum logic [1:0] {EBI_IDLE, EBI_INT, EBI_EXT, EBI_DRAIN} ebi_fsm_e;
endpackage

// file: rtl/ebi_link_if.sv
// Link between the bus controller, its address decoder and its state timer.
// Assumes all three modules share one clock.
`timescale 1ns/100ps
interface ebi_link_if;
   logic [15:0] addr;
   logic rom_en;
   logic ram_en;
   ebi_pkg::ebi_target_e target;
   logic start;
   logic [2:0] len;
   logic last;
   logic [2:0] idx;
   modport top (output addr, rom_en, ram_en, start, len, input target, last, idx);
   modport dec (input addr, rom_en, ram_en, output target);
   modport tmr (input start, len, output last, idx);
endinterface

// file: rtl/ebi_addr_decode.sv
// Address decoder: sorts a normal-mode address into on-chip or external space.
// Assumes enables arrive already synchronised to clock_in.
`timescale 1ns/100ps
`include "ebi_defs.svh"
module ebi_addr_decode (
   input wire logic clock_in,
   input wire logic reset_n_in,
   ebi_link_if.dec lk
);
   function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
      return (a >= lo) && (a <= hi);
   endfunction

   // Whatever is not on-chip goes out on the bus
   always_comb begin
      if (in_range(lk.addr, `EBI_IO_LO, `EBI_IO_HI)) begin
         lk.target = ebi_pkg::EBI_TGT_IO;
      end else if (lk.ram_en && in_range(lk.addr, `EBI_RAM_LO, `EBI_RAM_HI)) begin
         lk.target = ebi_pkg::EBI_TGT_RAM;
      end else if (lk.rom_en && in_range(lk.addr, `EBI_ROM_LO, `EBI_ROM_HI)) begin
         lk.target = ebi_pkg::EBI_TGT_ROM;
      end else begin
         lk.target = ebi_pkg::EBI_TGT_EXT;
      end
   end

   a_ram_off_ext: assert property (
      @(posedge clock_in) disable iff (!reset_n_in)
      (!lk.ram_en && lk.addr < `EBI_IO_LO && !(lk.rom_en && lk.addr <= `EBI_ROM_HI))
      |-> lk.target == ebi_pkg::EBI_TGT_EXT)
      else $error("disabled RAM address not sent external");
   a_rom_off_ext: assert property (
      @(posedge clock_in) disable iff (!reset_n_in)
      (!lk.rom_en && lk.addr <= `EBI_ROM_HI) |-> lk.target == ebi_pkg::EBI_TGT_EXT)
      else $error("ROM address not external with ROM disabled");
endmodule // ebi_addr_decode

// file: rtl/ebi_state_timer.sv
// State timer: counts the states of one bus or internal cycle.
// Assumes start is a one-cycle request with len of at least one.
`timescale 1ns/100ps
`include "ebi_defs.svh"
module ebi_state_timer (
   input wire logic clock_in,
   input wire logic reset_n_in,
   ebi_link_if.tmr lk
);
   logic busy_reg;
   logic [2:0] cnt_reg;
   logic [2:0] len_reg;

   // One count per clock period
   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         busy_reg <= 1'b0;
         cnt_reg <= 3'h0;
         len_reg <= 3'h1;
      end else if (lk.start) begin
         busy_reg <= 1'b1;
         cnt_reg <= 3'h0;
         len_reg <= lk.len;
      end else if (busy_reg) begin
         if (cnt_reg == len_reg - 3'h1) begin
            busy_reg <= 1'b0;
         end else begin
            cnt_reg <= cnt_reg + 3'h1;
         end
      end
   end

   assign lk.last = busy_reg && (cnt_reg == len_reg - 3'h1);
   assign lk.idx = cnt_reg;

   a_two_state_len: assert property (
      @(posedge clock_in) disable iff (!reset_n_in)
      (lk.start && lk.len == `EBI_ST_TWO) |=> !lk.last ##1 lk.last)
      else $error("two-state cycle not two states long");
endmodule // ebi_state_timer

// file: tb/ebi_mem_model.sv
// Byte-wide external memory on the two data lanes behind the area 0 select.
// Assumes the bench tells it whether the area is wired 8-bit.
`timescale 1ns/100ps
module ebi_mem_model (
   input wire logic clock_in,
   input wire logic w8_in,
   input wire logic [15:0] addr_in,
   input wire logic [15:0] data_in,
   input wire logic rd_n_in,
   input wire logic hwr_n_in,
   input wire logic lwr_n_in,
   input wire logic cs_n_in,
   output logic [15:0] data_out
);
   logic [7:0] mem [0:65535];
   logic [15:0] noise = 16'h5a5a;
   logic [15:0] hi_a;
   assign hi_a = w8_in ? addr_in : {addr_in[15:1], 1'b0};
   always @(posedge clock_in) begin
      noise <= noise + 16'h9e37;
      if (!cs_n_in && !hwr_n_in) mem[hi_a] <= data_in[15:8];
      if (!cs_n_in && !lwr_n_in) mem[addr_in | 16'h1] <= data_in[7:0];
   end
   // Both lanes show changing noise unless select and read strobe are low
   assign data_out = (!cs_n_in && !rd_n_in) ? {mem[hi_a], mem[addr_in | 16'h1]} : noise;
endmodule // ebi_mem_model

// file: tb/tb.sv
// Self-checking bench for the external bus controller with a memory model.
// Assumes one 100 MHz clock; the memory sits on the area 0 select.
`timescale 1ns/100ps
`include "ebi_defs.svh"
module tb;
   logic clk = 1'b0, rst_n = 1'b0, vld = 1'b0, wr = 1'b0, rom = 1'b0, ram = 1'b0, dw = 1'b0, cw = 1'b0;
   logic w8 = 1'b1, st = 1'b1, rdy, done, ia, rd_n, hw_n, lw_n, hoe, loe, wie;
   logic [1:0] sz = 2'h0, wt = 2'h3, tgt;
   logic [15:0] a = 16'h0, xa, xd, xin;
   logic [31:0] wd = 32'h0, rdat;
   logic [3:0] dir = 4'h0, cwid = 4'h0, cst = 4'h0, cwh = 4'h0, cwl = 4'h0, sel_n, sel_oe;
   int num_errors = 0, n_compared = 0, cyc = 0, lat;
   ebi_bus_ctrl i_dut (.clock_in(clk), .reset_n_in(rst_n), .req_valid_in(vld), .req_addr_in(a),
      .req_write_in(wr), .req_size_in(sz), .req_wdata_in(wd), .req_ready_out(rdy), .resp_done_out(done),
      .resp_rdata_out(rdat), .int_access_out(ia), .int_target_out(tgt), .rom_enable_in(rom),
      .onchip_ram_enable_in(ram), .cs_dir_write_in(dw), .cs_dir_in(dir), .cfg_write_in(cw),
      .area_width_bit_in(cwid), .area_state_bit_in(cst), .area_wait_hi_bit_in(cwh),
      .area_wait_lo_bit_in(cwl), .wait_input_enable_out(wie), .ext_addr_out(xa), .ext_data_out(xd),
      .ext_data_hi_oe_out(hoe), .ext_data_lo_oe_out(loe), .ext_data_in(xin), .read_strobe_n_out(rd_n),
      .upper_write_strobe_n_out(hw_n), .lower_write_strobe_n_out(lw_n), .area_select_n_out(sel_n),
      .area_select_oe_out(sel_oe));
   ebi_mem_model i_mem (.clock_in(clk), .w8_in(w8), .addr_in(xa), .data_in(xd), .rd_n_in(rd_n),
      .hwr_n_in(hw_n), .lwr_n_in(lw_n), .cs_n_in(sel_n[0]), .data_out(xin));
   initial begin
      forever #5 clk = ~clk;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic finish_test();
      if (num_errors == 0 && n_compared > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   // Size codes 0 and 3 both move a byte
   function automatic logic is_byte();
      return sz[0] == sz[1];
   endfunction
   function automatic logic [1:0] exp_tgt(input logic [15:0] ad);
      if (ad >= `EBI_IO_LO) return ebi_pkg::EBI_TGT_IO;
      if (ram && ad >= `EBI_RAM_LO) return ebi_pkg::EBI_TGT_RAM;
      if (rom && ad <= `EBI_ROM_HI) return ebi_pkg::EBI_TGT_ROM;
      return ebi_pkg::EBI_TGT_EXT;
   endfunction
   function automatic int exp_lat(input logic [1:0] t);
      int beats;
      if (t == ebi_pkg::EBI_TGT_IO) return 3;
      if (t != ebi_pkg::EBI_TGT_EXT) return 2;
      beats = is_byte() ? 1 : w8 ? (sz == 2'h1 ? 2 : 4) : (sz == 2'h1 ? 1 : 2);
      return beats * (st ? 3 + wt : 2) + (wr ? 1 : 3);
   endfunction
   task automatic op(input logic w);
      logic [1:0] t;
      @(posedge clk);
      vld <= 1'b1;
      wr <= w;
      @(negedge clk);
      t = exp_tgt(a);
      check(rdy, 1'b1);
      lat = 0;
      @(posedge clk);
      vld <= 1'b0;
      do begin
         @(negedge clk);
         lat++;
         if (lat == 1) check({ia, rdy}, {t != ebi_pkg::EBI_TGT_EXT, 1'b0});
      end while (done !== 1'b1 && lat < 300);
      check(ia, 1'b0);
      check(lat, exp_lat(t));
      check(tgt, t);
      if (!w) check(rdat, t == ebi_pkg::EBI_TGT_EXT ? wd & (is_byte() ? 32'hff : sz == 2'h1 ? 32'hffff : 32'hffffffff) : 32'h0);
   endtask
   task automatic do_reset(input logic r);
      @(posedge clk);
      rst_n <= 1'b0;
      rom <= r;
      {w8, st, wt} <= 4'hf;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(negedge clk);
      check(sel_oe, r ? `EBI_DIR_ROM_ON : `EBI_DIR_ROM_OFF);
      check(wie, 1'b0);
   endtask
   always @(negedge clk) begin
      if (rst_n) begin
         check(sel_n[3:1], 3'h7);
         if (!rd_n || !hw_n || !lw_n) check(sel_n[0], 1'b0);
         if (!rd_n) check({hw_n, lw_n, hoe, loe}, 4'hc);
         if (!hw_n || !lw_n) check({hw_n, lw_n, hoe, loe}, (w8 || (is_byte() && !a[0])) ? 4'h6 : is_byte() ? 4'h9 : 4'h3);
      end
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc > 30000) begin
         num_errors++;
         finish_test();
      end
   end
   initial begin
      void'($urandom(32'h8d47));
      for (int r = 0; r < 2; r++) begin
         do_reset(r[0]);
         @(posedge clk);
         dir <= 4'($urandom);
         dw <= 1'b1;
         @(posedge clk);
         dw <= 1'b0;
         repeat (2) @(negedge clk);
         check(sel_oe, dir);
         for (int i = 0; i < 60; i++) begin
            @(posedge clk);
            if (i > 0) {cwid, cst, cwh, cwl} <= 16'($urandom);
            ram <= (i > 0) ? 1'($urandom) : 1'b1;
            cw <= (i > 0);
            sz <= 2'($urandom);
            wd <= $urandom;
            @(posedge clk);
            cw <= 1'b0;
            if (i > 0) {w8, st, wt} <= {cwid[0], cst[0], cwh[0], cwl[0]};
            a <= i == 1 ? `EBI_RAM_LO : i == 2 ? `EBI_IO_LO : 16'($urandom) & (sz == 2'h2 ? 16'hfffc : sz == 2'h1 ? 16'hfffe : 16'hffff);
            op(1'b1);
            op(1'b0);
         end
      end
      finish_test();
   end
endmodule // tb
